// ==== rtl/rbc_top.sv ====
/*
 * Instrument bus remote/local control: remote and lockout state, talker and
 * listener addressing, device clear, trigger arming, serial poll and service
 * request, with an APB register slave.
 * Assumes command bytes arrive as one-cycle strobes on sys_clk from the bus
 * handshake logic; REN, IFC and front-panel keys are asynchronous pins.
 */
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "rbc_map.svh"
module rbc_top (
	input  wire logic            sys_clk,		// 125 MHz clock
	input  wire logic            rst_n,		// Async reset, active low
	input  wire logic            psel,		// APB select
	input  wire logic            penable,		// APB access phase
	input  wire logic            pwrite,		// APB write
	input  wire logic [7:0]      paddr,		// APB byte address
	input  wire logic [31:0]     pwdata,		// APB write data
	output logic      [31:0]     prdata,		// APB read data
	output logic                 pready,		// APB ready
	output logic                 pslverr,		// APB error, unmapped
	input  wire logic            ren_pin,		// Remote enable line
	input  wire logic            ifc_pin,		// Interface clear line
	input  wire logic            msg_stb,		// Command byte strobe
	input  wire logic [7:0]      msg_byte,		// Command byte
	input  wire logic            spoll_rd,		// Poll byte read strobe
	input  wire logic            local_key,		// Local key pin
	input  wire logic            manual_arm_key,	// Trigger key pin
	input  wire logic            out_key,		// Output on/off key pin
	output rbc_pkg::rbc_rl_t     rl_state,		// Remote/local state
	output logic                 remote_indicator,	// In remote
	output logic                 lockout,		// Lockout active
	output logic                 talk_indicator,	// Talker active
	output logic                 listener_active_indicator, // Listener active
	output logic                 spoll_mode,	// Serial poll mode
	output logic      [7:0]      poll_byte,		// Status byte to bus
	output logic                 srq_out,		// Service request
	output logic                 dev_clear,		// Clear pulse
	output logic                 arm_event,		// Arm pulse
	output logic                 abort_pulse,	// Abort and idle pulse
	output logic                 acq_enable,	// Acquisition allowed
	output logic                 panel_keys_enable,	// General keys usable
	output logic                 local_key_enable,	// Local key usable
	output logic                 manual_arm_key_press,	// Accepted trigger press
	output logic                 out_press		// Accepted output press
);
	import rbc_pkg::*;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [4:0] pins_q;	// Filtered pin levels
	logic       ren_lvl;	// REN filtered
	logic       ifc_lvl;	// IFC filtered
	logic       lk_lvl;	// Local key filtered
	logic       tk_lvl;	// Trigger key filtered
	logic       ok_lvl;	// Output key filtered
	logic [2:0] key_prev_q;	// Key levels last cycle

	rbc_sync #(.W(5)) u_sync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in ({out_key, manual_arm_key, local_key, ifc_pin, ren_pin}),
		.clean_q  (pins_q)
	);
	assign {ok_lvl, tk_lvl, lk_lvl, ifc_lvl, ren_lvl} = pins_q;

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	logic [31:0] ctrl_q;	// Address and arm source
	logic [7:0]  spb_q;	// Status conditions
	logic [7:0]  sre_q;	// Request enable mask
	logic [4:0]  my_addr;	// Primary address
	logic [1:0]  arm_src;	// Arm control source

	assign my_addr = ctrl_q[`RBC_CTRL_ADR_MSB:`RBC_CTRL_ADR_LSB];
	assign arm_src = ctrl_q[`RBC_CTRL_ARM_MSB:`RBC_CTRL_ARM_LSB];

	// ---------------------------------------------------------------
	// Command decode
	// ---------------------------------------------------------------
	logic mla_hit;	// My listen address
	logic mta_hit;	// My talk address
	logic ota_hit;	// Other talk address
	logic unl_hit;	// Unlisten
	logic unt_hit;	// Untalk
	logic gtl_hit;	// Go to local, addressed
	logic llo_hit;	// Local lockout
	logic dcl_hit;	// Device clear
	logic sdc_hit;	// Selective clear
	logic get_hit;	// Group trigger
	logic spe_hit;	// Poll enable
	logic spd_hit;	// Poll disable
	logic lacs;	// Listener active now
	logic tacs;	// Talker active now

	assign mla_hit = msg_stb && msg_byte == {`RBC_GRP_LSN, my_addr};
	assign mta_hit = msg_stb && msg_byte == {`RBC_GRP_TLK, my_addr};
	assign ota_hit = msg_stb && msg_byte[7:5] == `RBC_GRP_TLK && !mta_hit
	                 && msg_byte != `RBC_CMD_UNT;
	assign unl_hit = msg_stb && msg_byte == `RBC_CMD_UNL;
	assign unt_hit = msg_stb && msg_byte == `RBC_CMD_UNT;
	assign gtl_hit = msg_stb && msg_byte == `RBC_CMD_GTL && lacs;
	assign llo_hit = msg_stb && msg_byte == `RBC_CMD_LLO;
	assign dcl_hit = msg_stb && msg_byte == `RBC_CMD_DCL;
	assign sdc_hit = msg_stb && msg_byte == `RBC_CMD_SDC;
	assign get_hit = msg_stb && msg_byte == `RBC_CMD_GET;
	assign spe_hit = msg_stb && msg_byte == `RBC_CMD_SPE;
	assign spd_hit = msg_stb && msg_byte == `RBC_CMD_SPD;

	// ---------------------------------------------------------------
	// Talker and listener states
	// ---------------------------------------------------------------
	rbc_tk_t tk_q;	// Talker state
	rbc_tk_t tk_d;	// Talker next
	rbc_ls_t ls_q;	// Listener state
	rbc_ls_t ls_d;	// Listener next

	assign tacs = tk_q == RBC_TACS;
	assign lacs = ls_q == RBC_LACS;

	// Talker next state
	always_comb begin
		tk_d = tk_q;
		if (ifc_lvl) begin
			tk_d = RBC_TIDS;
		end else if (mta_hit) begin
			tk_d = RBC_TACS;
		end else if (unt_hit || mla_hit || ota_hit) begin
			tk_d = RBC_TIDS;
		end
	end

	// Listener next state
	always_comb begin
		ls_d = ls_q;
		if (ifc_lvl) begin
			ls_d = RBC_LIDS;
		end else if (mla_hit) begin
			ls_d = RBC_LACS;
		end else if (unl_hit || mta_hit) begin
			ls_d = RBC_LIDS;
		end
	end

	// ---------------------------------------------------------------
	// Remote/local state machine
	// ---------------------------------------------------------------
	rbc_rl_t rl_q;		// Current state
	rbc_rl_t rl_d;		// Next state
	logic    lk_press;	// Local key rising edge
	logic    rem_d;		// Remote next
	logic    llo_d;		// Lockout next

	assign lk_press = lk_lvl && !key_prev_q[0];

	// Next remote/local state; REN loss has priority in REMS, GTL wins in RWLS
	always_comb begin
		case (rl_q)
			RBC_LOCS: begin
				// Listen address with REN enters remote
				if (ren_lvl && mla_hit) begin
					rl_d = RBC_REMS;
				end else if (ren_lvl && llo_hit) begin
					rl_d = RBC_LWLS;
				end else begin
					rl_d = RBC_LOCS;
				end
			end
			RBC_REMS: begin
				if (!ren_lvl || gtl_hit) begin
					rl_d = RBC_LOCS;
				end else if (llo_hit) begin
					rl_d = RBC_RWLS;
				end else if (lk_press) begin
					rl_d = RBC_LOCS;
				end else begin
					rl_d = RBC_REMS;
				end
			end
			RBC_LWLS: begin
				if (gtl_hit) begin
					rl_d = RBC_LOCS;
				end else if (ren_lvl && mla_hit) begin
					rl_d = RBC_RWLS;
				end else begin
					rl_d = RBC_LWLS;
				end
			end
			RBC_RWLS: begin
				if (gtl_hit) begin
					rl_d = RBC_LOCS;
				end else if (!ren_lvl) begin
					rl_d = RBC_LWLS;
				end else begin
					rl_d = RBC_RWLS;
				end
			end
			default: begin
				rl_d = RBC_LOCS;
			end
		endcase
	end

	assign rem_d = rl_d == RBC_REMS || rl_d == RBC_RWLS;
	assign llo_d = rl_d == RBC_LWLS || rl_d == RBC_RWLS;

	// ---------------------------------------------------------------
	// Serial poll and service request
	// ---------------------------------------------------------------
	logic       spm_q;		// Poll mode latched
	logic [7:0] cond;		// Enabled request causes
	logic [7:0] cond_prev_q;	// Causes last cycle
	logic       cond_new;	// A cause has risen
	logic       poll_taken;	// Poll byte read
	logic       srq_d;		// Request next

	assign cond       = spb_q & sre_q & `RBC_RQS_MASK;
	assign cond_new   = |(cond & ~cond_prev_q);
	assign poll_taken = spoll_rd && spm_q && tacs;
	// New cause wins over read; hold until read or causes gone
	assign srq_d      = cond_new || (srq_out && !poll_taken && |cond);

	// ---------------------------------------------------------------
	// APB slave
	// ---------------------------------------------------------------
	logic        setup;		// Setup phase
	logic        wr_do;		// Write takes effect
	logic        mapped;	// Known offset
	logic [31:0] rd_mux;	// Read data selection
	logic [31:0] stat_word;	// Status image

	assign setup  = psel && !penable;
	assign wr_do  = psel && penable && pready && pwrite && !pslverr;
	assign mapped = paddr == `RBC_OFF_CTRL || paddr == `RBC_OFF_STAT
	                || paddr == `RBC_OFF_SPB || paddr == `RBC_OFF_SRE;
	assign stat_word = {26'h0, spoll_mode, srq_out, listener_active_indicator,
	                    talk_indicator, lockout, remote_indicator};
	assign rd_mux = (paddr == `RBC_OFF_CTRL) ? ctrl_q :
	                (paddr == `RBC_OFF_STAT) ? stat_word :
	                (paddr == `RBC_OFF_SPB)  ? {24'h0, spb_q} :
	                (paddr == `RBC_OFF_SRE)  ? {24'h0, sre_q} : 32'h0000_0000;

	// Bus answer: ready in first access cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup && !mapped;
			prdata  <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// Register writes; status word is read only
	// Nothing on the bus side touches these but software
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= `RBC_CTRL_RST;
			spb_q  <= `RBC_SPB_RST;
			sre_q  <= `RBC_SRE_RST;
		end else if (wr_do) begin
			if (paddr == `RBC_OFF_CTRL) ctrl_q <= pwdata;
			if (paddr == `RBC_OFF_SPB)  spb_q  <= pwdata[7:0];
			if (paddr == `RBC_OFF_SRE)  sre_q  <= pwdata[7:0];
		end
	end

	// ---------------------------------------------------------------
	// State registers
	// ---------------------------------------------------------------
	// Reset gives local, unlocked, idle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rl_q <= RBC_LOCS;
			tk_q <= RBC_TIDS;
			ls_q <= RBC_LIDS;
		end else begin
			rl_q <= rl_d;
			tk_q <= tk_d;
			ls_q <= ls_d;
		end
	end

	// Indicators and key enables, all registered
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rl_state                  <= RBC_LOCS;
			remote_indicator          <= 1'b0;
			lockout                   <= 1'b0;
			talk_indicator            <= 1'b0;
			listener_active_indicator <= 1'b0;
			acq_enable                <= 1'b0;
			panel_keys_enable         <= 1'b1;
			local_key_enable          <= 1'b1;
			abort_pulse               <= 1'b0;
		end else begin
			rl_state                  <= rl_d;
			remote_indicator          <= rem_d;
			lockout                   <= llo_d;
			talk_indicator            <= tk_d == RBC_TACS;
			listener_active_indicator <= ls_d == RBC_LACS;
			acq_enable                <= rem_d;
			panel_keys_enable         <= !rem_d && !llo_d;
			local_key_enable          <= !llo_d;
			abort_pulse               <= rem_d != remote_indicator;
		end
	end

	// Clear, arm, poll and key pulses
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dev_clear   <= 1'b0;
			arm_event   <= 1'b0;
			spm_q       <= 1'b0;
			spoll_mode  <= 1'b0;
			srq_out     <= 1'b0;
			poll_byte   <= 8'h00;
			cond_prev_q <= 8'h00;
			key_prev_q  <= 3'h0;
			manual_arm_key_press  <= 1'b0;
			out_press   <= 1'b0;
		end else begin
			// DCL always, SDC only when addressed
			dev_clear   <= dcl_hit || (sdc_hit && lacs);
			// GET arms only with bus source
			arm_event   <= get_hit && arm_src == `RBC_ARM_BUS;
			spm_q       <= ifc_lvl ? 1'b0 : (spe_hit || (spm_q && !spd_hit));
			spoll_mode  <= ifc_lvl ? 1'b0 : (spe_hit || (spm_q && !spd_hit));
			srq_out     <= srq_d;
			poll_byte   <= (spb_q & `RBC_RQS_MASK) | ({7'h00, srq_d} << `RBC_RQS_BIT);
			cond_prev_q <= cond;
			key_prev_q  <= {ok_lvl, tk_lvl, lk_lvl};
			// Manual trigger key live in any remote/local state, only with manual arm source
			manual_arm_key_press  <= tk_lvl && !key_prev_q[1] && arm_src == `RBC_ARM_MAN;
			out_press   <= ok_lvl && !key_prev_q[2];
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_rem_entry_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(remote_indicator) |-> $past(mla_hit && ren_lvl))
		else $error("remote entered without listen address and REN");
	a_ifc_idles_both: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ifc_lvl |=> !talk_indicator && !listener_active_indicator)
		else $error("IFC did not idle talker and listener");
	a_llo_exit_gtl: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(lockout) |-> $past(gtl_hit))
		else $error("lockout left without GTL");
	a_gtl_to_local: assert property (@(posedge sys_clk) disable iff (!rst_n)
		gtl_hit |=> !remote_indicator && !lockout)
		else $error("GTL did not return to local");
	a_dcl_always: assert property (@(posedge sys_clk) disable iff (!rst_n)
		dcl_hit |=> dev_clear)
		else $error("DCL did not clear");
	a_sdc_addressed: assert property (@(posedge sys_clk) disable iff (!rst_n)
		dev_clear |-> $past(dcl_hit || (sdc_hit && lacs)))
		else $error("clear without DCL or addressed SDC");
	a_get_arm_src: assert property (@(posedge sys_clk) disable iff (!rst_n)
		arm_event |-> $past(get_hit && arm_src == `RBC_ARM_BUS))
		else $error("arm event without bus-sourced GET");
	a_keys_locked: assert property (@(posedge sys_clk) disable iff (!rst_n)
		remote_indicator |-> !panel_keys_enable && (local_key_enable != lockout))
		else $error("keys not locked in remote");
	a_srq_hold_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(srq_out) |-> $past(poll_taken || cond == 8'h00))
		else $error("service request dropped without cause");
	a_abort_on_change: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$changed(remote_indicator) |-> abort_pulse ##1 !abort_pulse)
		else $error("no single abort pulse on remote change");
	a_acq_remote: assert property (@(posedge sys_clk) disable iff (!rst_n)
		acq_enable == remote_indicator)
		else $error("acquisition enable differs from remote");

endmodule

// ==== rtl/rbc_map.svh ====
/*
 * Offsets, field positions, reset values and bus command codes of the
 * remote/local control block. Assumes a 32-bit APB register bus and an
 * upstream handshake that hands over each command byte (ATN true) as a strobe.
 */
`ifndef RBC_MAP_SVH
`define RBC_MAP_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define RBC_OFF_CTRL     8'h00
`define RBC_OFF_STAT     8'h04
`define RBC_OFF_SPB      8'h08
`define RBC_OFF_SRE      8'h0C

// ---------------------------------------------------------------
// Control register fields and reset value
// ---------------------------------------------------------------
`define RBC_CTRL_ADR_LSB 0
`define RBC_CTRL_ADR_MSB 4
`define RBC_CTRL_ARM_LSB 8
`define RBC_CTRL_ARM_MSB 9
`define RBC_CTRL_RST     32'h0000_0018
`define RBC_ARM_IMM      2'h0
`define RBC_ARM_BUS      2'h1
`define RBC_ARM_MAN      2'h2

// ---------------------------------------------------------------
// Status register bit positions
// ---------------------------------------------------------------
`define RBC_ST_REM       0
`define RBC_ST_LLO       1
`define RBC_ST_TALK      2
`define RBC_ST_LISTENER_ACTIVE_INDICATOR      3
`define RBC_ST_SRQ       4
`define RBC_ST_SPM       5

// ---------------------------------------------------------------
// Poll byte and enable mask
// ---------------------------------------------------------------
`define RBC_SPB_RST      8'h00
`define RBC_SRE_RST      8'h00
`define RBC_RQS_BIT      6
`define RBC_RQS_MASK     8'hBF

// ---------------------------------------------------------------
// Bus command bytes
// ---------------------------------------------------------------
`define RBC_CMD_GTL      8'h01
`define RBC_CMD_SDC      8'h04
`define RBC_CMD_GET      8'h08
`define RBC_CMD_LLO      8'h11
`define RBC_CMD_DCL      8'h14
`define RBC_CMD_SPE      8'h18
`define RBC_CMD_SPD      8'h19
`define RBC_CMD_UNL      8'h3F
`define RBC_CMD_UNT      8'h5F
`define RBC_GRP_LSN      3'h1
`define RBC_GRP_TLK      3'h2

`endif

// ==== rtl/rbc_pkg.sv ====
/*
 * Types of the remote/local control block: one-hot state encodings.
 * Assumes the map header supplies all numeric constants.
 */
package rbc_pkg;

	// Remote/local state with lockout folded in
	typedef enum logic [3:0] {
		RBC_LOCS = 4'h1,	// Local
		RBC_REMS = 4'h2,	// Remote
		RBC_LWLS = 4'h4,	// Local, locked out
		RBC_RWLS = 4'h8		// Remote, locked out
	} rbc_rl_t;

	// Talker function state
	typedef enum logic [1:0] {
		RBC_TIDS = 2'h1,	// Talker idle
		RBC_TACS = 2'h2		// Talker active
	} rbc_tk_t;

	// Listener function state
	typedef enum logic [1:0] {
		RBC_LIDS = 2'h1,	// Listener idle
		RBC_LACS = 2'h2		// Listener active
	} rbc_ls_t;

endpackage

// ==== rtl/rbc_sync.sv ====
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes inputs are asynchronous to sys_clk; output changes once stages
 * two and three agree.
 */
`timescale 1ns/1ps
module rbc_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,	// System clock
	input  wire logic         rst_n,	// Async reset, active low
	input  wire logic [W-1:0] async_in,	// Raw pin levels
	output logic      [W-1:0] clean_q	// Filtered levels
);

	logic [W-1:0] s1_q;	// First stage, read by s2 only
	logic [W-1:0] s2_q;	// Second stage
	logic [W-1:0] s3_q;	// Third stage
	logic [W-1:0] agree;	// Stages two and three equal

	assign agree = ~(s2_q ^ s3_q);

	// ---------------------------------------------------------------
	// Shift chain and filtered output
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q    <= '0;
			s2_q    <= '0;
			s3_q    <= '0;
			clean_q <= '0;
		end else begin
			s1_q    <= async_in;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			clean_q <= (agree & s3_q) | (~agree & clean_q);
		end
	end

endmodule

// ==== tb/rbc_ctl_model.sv ====
/* Bus controller model: command bytes, REN, IFC and poll reads.
 * Assumes tasks are called right after a sys_clk rising edge. */
`timescale 1ns/1ps
module rbc_ctl_model (
	input  wire logic       sys_clk,	// System clock
	output logic            ren_pin,	// Remote enable
	output logic            ifc_pin,	// Interface clear
	output logic            msg_stb,	// Command strobe
	output logic      [7:0] msg_byte,	// Command byte
	output logic            spoll_rd	// Poll byte read
);
	// Idle levels at time zero
	initial begin
		{ren_pin, ifc_pin, msg_stb, spoll_rd} = 4'h0;
		msg_byte = 8'h00;
	end
	task send(input logic [7:0] b);
		msg_stb <= 1'b1;
		msg_byte <= b;
		@(posedge sys_clk);
		msg_stb <= 1'b0;
		msg_byte <= ~b;
		repeat (2) @(posedge sys_clk);
	endtask
	// Remote enable level, then sync time
	task ren_set(input logic v);
		ren_pin <= v;
		repeat (8) @(posedge sys_clk);
	endtask
	task clear();
		ifc_pin <= 1'b1;
		repeat (12500) @(posedge sys_clk);
		ifc_pin <= 1'b0;
		repeat (8) @(posedge sys_clk);
	endtask
	// Poll byte taken by the bus
	task poll();
		spoll_rd <= 1'b1;
		@(posedge sys_clk);
		spoll_rd <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask
endmodule

// ==== tb/bus_remote_local_control_test.sv ====
/* Self-checking bench of the remote/local control block.
 * Assumes rbc_ctl_model stands in for the bus controller. */
`timescale 1ns/1ps
`include "rbc_map.svh"
module bus_remote_local_control_test;
	typedef struct packed {logic [1:0] sel; logic [31:0] exp;} rbc_note_t;
	logic sys_clk = 0, rst_n = 0, psel, penable, pwrite;
	logic [7:0] paddr, msg_byte, poll_byte, bc = 0, tc = 0, ac = 0, dc = 0;
	logic [31:0] pwdata, prdata, rd, r, d;
	logic pready, pslverr, er, ren_pin, ifc_pin, msg_stb, spoll_rd, spoll_mode;
	logic [2:0] keys;
	logic [3:0] oc = 4'h0;
	logic remote_indicator, lockout, talk_indicator, listener_active_indicator, srq_out;
	logic dev_clear, arm_event, abort_pulse, acq_enable, panel_keys_enable;
	logic local_key_enable, manual_arm_key_press, out_press;
	rbc_pkg::rbc_rl_t rl_state;
	int miscompares = 0, checks_done = 0, cyc = 0;
	rbc_note_t notes[$], n;
	wire [7:0] obs = {acq_enable, panel_keys_enable, local_key_enable, srq_out, lockout,
		listener_active_indicator, talk_indicator, remote_indicator};
	rbc_top u_dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .ren_pin, .ifc_pin, .msg_stb, .msg_byte, .spoll_rd,
		.local_key(keys[0]), .manual_arm_key(keys[1]), .out_key(keys[2]), .rl_state,
		.remote_indicator, .lockout, .talk_indicator, .listener_active_indicator,
		.spoll_mode, .poll_byte, .srq_out, .dev_clear, .arm_event, .abort_pulse,
		.acq_enable, .panel_keys_enable, .local_key_enable, .manual_arm_key_press, .out_press);
	rbc_ctl_model u_ctl (.sys_clk, .ren_pin, .ifc_pin, .msg_stb, .msg_byte, .spoll_rd);
	always #4 sys_clk = ~sys_clk;
	// Pulse counters and hang limit
	always @(posedge sys_clk) begin
		bc <= bc + 8'(abort_pulse);
		tc <= tc + 8'(manual_arm_key_press);
		ac <= ac + 8'(arm_event);
		dc <= dc + 8'(dev_clear);
		oc <= oc + 4'(out_press);
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			end_of_test();
		end
	end
	// Monitor: every queued note, oldest first, against what is seen
	always @(negedge sys_clk) begin
		while (notes.size() > 0) begin
			n = notes.pop_front();
			case (n.sel)
				2'h0: check({24'h0, obs}, n.exp);
				2'h1: check({bc, tc, ac, dc}, n.exp);
				2'h2: check(rd, n.exp);
				default: check({14'h0, oc, spoll_mode, rl_state, er, poll_byte}, n.exp);
			endcase
		end
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task note(input logic [1:0] s, input logic [31:0] e);
		notes.push_back('{s, e});
	endtask
	// APB transfer, waits for pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dat;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	// Key held pressed, then released
	task press(input int k);
		keys[k] <= 1'b1;
		repeat (8) @(posedge sys_clk);
		keys[k] <= 1'b0;
		repeat (8) @(posedge sys_clk);
	endtask
	task end_of_test();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Main sequence
	initial begin
		r = $urandom(89192);
		{psel, penable, pwrite, keys} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		note(0, 32'h60);
		apb(0, `RBC_OFF_CTRL, 0);
		note(2, `RBC_CTRL_RST);
		$display("reset test done");
		u_ctl.send(8'h38);
		note(0, 32'h64);
		u_ctl.send(`RBC_CMD_UNL);
		note(0, 32'h60);
		u_ctl.ren_set(1'b1);
		note(0, 32'h60);
		u_ctl.send(8'h38);
		note(0, 32'hA5);
		u_ctl.send(8'h58);
		note(0, 32'hA3);
		u_ctl.send(`RBC_CMD_UNT);
		note(0, 32'hA1);
		$display("addressing test done");
		u_ctl.send(`RBC_CMD_SDC);
		note(1, 32'h01000000);
		u_ctl.send(`RBC_CMD_DCL);
		note(1, 32'h01000001);
		u_ctl.send(8'h38);
		u_ctl.send(`RBC_CMD_SDC);
		note(1, 32'h01000002);
		for (int s = 0; s < 3; s++) begin
			apb(1, `RBC_OFF_CTRL, 32'h18 | (s << 8));
			u_ctl.send(`RBC_CMD_GET);
			note(1, 32'h01000002 | ((s > 0) << 8));
		end
		press(1);
		note(1, 32'h01010102);
		press(0);
		note(0, 32'h64);
		$display("clear and arm test done");
		u_ctl.send(8'h38);
		u_ctl.send(`RBC_CMD_LLO);
		press(0);
		note(0, 32'h8D);
		press(2);
		note(3, 32'h5000);
		u_ctl.send(`RBC_CMD_DCL);
		u_ctl.clear();
		note(0, 32'h89);
		apb(0, `RBC_OFF_CTRL, 0);
		note(2, 32'h218);
		u_ctl.send(8'h38);
		u_ctl.send(`RBC_CMD_GTL);
		note(0, 32'h64);
		note(1, 32'h04010103);
		$display("lockout test done");
		r = $urandom;
		d = {24'h0, r[7:1], 1'b1};
		apb(1, `RBC_OFF_SRE, 32'h01);
		apb(1, `RBC_OFF_SPB, d);
		repeat (2) @(posedge sys_clk);
		note(0, 32'h74);
		note(3, (d & 32'hBF) | 32'h4240);
		u_ctl.send(`RBC_CMD_SPE);
		u_ctl.send(8'h58);
		u_ctl.poll();
		note(0, 32'h62);
		note(3, (d & 32'hBF) | 32'h6200);
		apb(1, `RBC_OFF_STAT, $urandom);
		apb(0, `RBC_OFF_STAT, 0);
		note(2, 32'h24);
		apb(1, 8'h10, r);
		apb(0, 8'h10, 0);
		note(3, 32'h6300 | (d & 32'hBF));
		$display("poll test done");
		repeat (2) @(posedge sys_clk);
		end_of_test();
	end
endmodule
